// ==== verilog/root_hub_pkg.sv ====
// constants for the root-hub power and status register logic
package root_hub_pkg;

	// ************************************************************
	// command codes
	// ************************************************************
	localparam logic [7:0] CODE_DESC_B_RD = 8'h13;
	localparam logic [7:0] CODE_DESC_B_WR = 8'h93;
	localparam logic [7:0] CODE_STATUS_RD = 8'h14;
	localparam logic [7:0] CODE_STATUS_WR = 8'h94;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int MASK_LSB        = 16;
	localparam int REMOVABLE_LSB   = 0;
	localparam int FIELD_W         = 16;
	localparam int BIT_WAKE_CLEAR  = 31;
	localparam int BIT_OC_CHANGE   = 17;
	localparam int BIT_GLOBAL_ON   = 16;
	localparam int BIT_WAKE_ENABLE = 15;
	localparam int BIT_OC_IND      = 1;
	localparam int BIT_GLOBAL_OFF  = 0;

	// ************************************************************
	// values after reset
	// ************************************************************
	localparam logic [15:0] MASK_RESET      = 16'h0000;
	localparam logic [15:0] REMOVABLE_RESET = 16'h0000;
	localparam logic        WAKE_RESET      = 1'b0;
	localparam logic        OC_CHANGE_RESET = 1'b0;
	localparam logic        POWER_RESET     = 1'b0;
	localparam logic [31:0] RD_DATA_RESET   = 32'h0000_0000;

endpackage

// ==== verilog/port_power_cell.sv ====
// power state of one downstream port
`timescale 1ns/1ps

module port_power_cell
(
	// clock and reset
	input  wire logic ref_clk_i,
	input  wire logic reset_i,
	input  wire logic clk_en_i,
	// mode and mask
	input  wire logic power_switch_select_i,
	input  wire logic mask_bit_i,
	// commands
	input  wire logic global_on_i,
	input  wire logic global_off_i,
	input  wire logic port_on_i,
	input  wire logic port_off_i,
	// power switch
	output logic      power_o
);

	logic per_port_owned;
	logic power_next;

	// ************************************************************
	// command selection
	// ************************************************************
	// in global mode the mask is ignored entirely
	assign per_port_owned = power_switch_select_i && mask_bit_i;

	always_comb
	begin
		power_next = power_o;
		if (per_port_owned)
		begin
			// masked port follows only per-port commands
			if (port_off_i)
				power_next = 1'b0;
			else if (port_on_i)
				power_next = 1'b1;
		end
		else
		begin
			// unmasked or global mode: global commands, off first
			if (global_off_i)
				power_next = 1'b0;
			else if (global_on_i)
				power_next = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
			power_o <= root_hub_pkg::POWER_RESET;
		else if (clk_en_i)
			power_o <= power_next;
	end

	// ************************************************************
	// checks
	// ************************************************************
	a_mask_blocks_global: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		clk_en_i && power_switch_select_i && mask_bit_i && !port_on_i && !port_off_i
		|=> power_o == $past(power_o))
		else $error("masked port changed on a global command");

	a_global_drives_port: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		clk_en_i && power_switch_select_i && !mask_bit_i && global_on_i && !global_off_i
		|=> power_o)
		else $error("unmasked port missed global power on");

	a_global_mode_off: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		clk_en_i && !power_switch_select_i && global_off_i |=> !power_o)
		else $error("global mode off did not act despite mask");

endmodule // port_power_cell

// ==== verilog/root_hub_power_status_regs.sv ====
// root-hub descriptor-b and hub status registers with port power control
`timescale 1ns/1ps

// Function
// - in per-port mode, masked port power changes only by per-port commands, global ones ignored
// - unmasked port power follows set and clear global power commands
// - in global switching mode the whole power mask is disregarded
// - mask bit 0 reserved; mask bit n serves downstream port n
// - removable flags in low half, bit 0 reserved, one means not removable
// - descriptor-b read with code 13h, written with code 93h
// - hub status in low half, status change bits in high half
// - writing one to bit 31 clears remote wake enable; zero does nothing
// - bit 17 set on overcurrent indicator change, cleared by writing one
// - bit 16 write powers all ports, or unmasked ones in per-port mode
// - bit 0 write unpowers all ports, or unmasked ones in per-port mode
module root_hub_power_status_regs
#(
	parameter int NUM_PORTS = 2
)
(
	// clock and reset
	input  wire logic                 ref_clk_i,
	input  wire logic                 reset_i,
	input  wire logic                 clk_en_i,
	// command port
	input  wire logic                 cmd_valid_i,
	input  wire logic [7:0]           cmd_code_i,
	input  wire logic [31:0]          wr_data_i,
	output logic                      rd_valid_o,
	output logic [31:0]               rd_data_o,
	// mode and status inputs
	input  wire logic                 power_switch_select_i,
	input  wire logic                 overcurrent_i,
	// per-port power commands, index 0 is port one
	input  wire logic [NUM_PORTS-1:0] port_power_on_i,
	input  wire logic [NUM_PORTS-1:0] port_power_off_i,
	// port power switches, index 0 is port one
	output logic [NUM_PORTS-1:0]      port_power_o
);

	// ************************************************************
	// declarations
	// ************************************************************
	localparam logic [16:0] ONES      = (17'h1 << NUM_PORTS) - 17'h1;
	localparam logic [15:0] PORT_BITS = {ONES[14:0], 1'b0};

	logic [15:0] mask_reg;
	logic [15:0] removable_reg;
	logic        wake_enable_reg;
	logic        oc_change_reg;
	logic        oc_seen_reg;
	logic        wr_desc_b;
	logic        wr_status;
	logic        global_on;
	logic        global_off;
	logic        oc_changed;
	logic [31:0] status_word;
	logic [31:0] desc_b_word;

	function automatic logic cmd_is(input logic [7:0] code);
		cmd_is = clk_en_i && cmd_valid_i && (cmd_code_i == code);
	endfunction

	// ************************************************************
	// command decode
	// ************************************************************
	assign wr_desc_b  = cmd_is(root_hub_pkg::CODE_DESC_B_WR);
	assign wr_status  = cmd_is(root_hub_pkg::CODE_STATUS_WR);
	assign global_on  = wr_status && wr_data_i[root_hub_pkg::BIT_GLOBAL_ON];
	assign global_off = wr_status && wr_data_i[root_hub_pkg::BIT_GLOBAL_OFF];
	assign oc_changed = overcurrent_i != oc_seen_reg;

	// ************************************************************
	// descriptor-b register
	// ************************************************************
	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			mask_reg      <= root_hub_pkg::MASK_RESET;
			removable_reg <= root_hub_pkg::REMOVABLE_RESET;
		end
		else if (wr_desc_b)
		begin
			// bit 0 and absent ports stay zero
			mask_reg      <= wr_data_i[root_hub_pkg::MASK_LSB +: root_hub_pkg::FIELD_W]
			                 & PORT_BITS;
			removable_reg <= wr_data_i[root_hub_pkg::REMOVABLE_LSB +: root_hub_pkg::FIELD_W]
			                 & PORT_BITS;
		end
	end

	// ************************************************************
	// hub status register
	// ************************************************************
	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
			wake_enable_reg <= root_hub_pkg::WAKE_RESET;
		else if (wr_status && wr_data_i[root_hub_pkg::BIT_WAKE_CLEAR])
			wake_enable_reg <= 1'b0;
		else if (wr_status && wr_data_i[root_hub_pkg::BIT_WAKE_ENABLE])
			wake_enable_reg <= 1'b1;
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			oc_seen_reg   <= 1'b0;
			oc_change_reg <= root_hub_pkg::OC_CHANGE_RESET;
		end
		else if (clk_en_i)
		begin
			oc_seen_reg <= overcurrent_i;
			// a change in the clearing cycle keeps the flag set
			if (oc_changed)
				oc_change_reg <= 1'b1;
			else if (wr_status && wr_data_i[root_hub_pkg::BIT_OC_CHANGE])
				oc_change_reg <= 1'b0;
		end
	end

	// ************************************************************
	// read path
	// ************************************************************
	always_comb
	begin
		status_word = 32'h0000_0000;
		status_word[root_hub_pkg::BIT_OC_CHANGE]   = oc_change_reg;
		status_word[root_hub_pkg::BIT_WAKE_ENABLE] = wake_enable_reg;
		status_word[root_hub_pkg::BIT_OC_IND]      = oc_seen_reg;
		desc_b_word = {mask_reg, removable_reg};
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			rd_valid_o <= 1'b0;
			rd_data_o  <= root_hub_pkg::RD_DATA_RESET;
		end
		else if (clk_en_i)
		begin
			rd_valid_o <= 1'b0;
			if (cmd_is(root_hub_pkg::CODE_DESC_B_RD))
			begin
				rd_valid_o <= 1'b1;
				rd_data_o  <= desc_b_word;
			end
			else if (cmd_is(root_hub_pkg::CODE_STATUS_RD))
			begin
				rd_valid_o <= 1'b1;
				rd_data_o  <= status_word;
			end
		end
	end

	// ************************************************************
	// port power switches
	// ************************************************************
	generate
		for (genvar p = 0; p < NUM_PORTS; p++)
		begin : g_port
			port_power_cell u_cell
			(
				.ref_clk_i             (ref_clk_i),
				.reset_i               (reset_i),
				.clk_en_i              (clk_en_i),
				.power_switch_select_i (power_switch_select_i),
				.mask_bit_i            (mask_reg[p+1]),
				.global_on_i           (global_on),
				.global_off_i          (global_off),
				.port_on_i             (port_power_on_i[p]),
				.port_off_i            (port_power_off_i[p]),
				.power_o               (port_power_o[p])
			);
		end
	endgenerate

	// ************************************************************
	// checks
	// ************************************************************
	a_reserved_bits_zero: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		mask_reg[0] == 1'b0 && removable_reg[0] == 1'b0)
		else $error("reserved descriptor-b bit 0 became set");

	a_desc_b_write: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		clk_en_i && cmd_valid_i && cmd_code_i == 8'h93
		|=> {mask_reg, removable_reg} == ($past(wr_data_i) & {PORT_BITS, PORT_BITS}))
		else $error("descriptor-b write not stored");

	a_desc_b_readback: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		clk_en_i && cmd_valid_i && cmd_code_i == 8'h13
		|=> rd_valid_o && rd_data_o[15:0] == $past(removable_reg))
		else $error("removable flags not returned in low half");

	a_status_layout: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		clk_en_i && cmd_valid_i && cmd_code_i == 8'h14
		|=> rd_valid_o && rd_data_o[15] == $past(wake_enable_reg)
		    && rd_data_o[17] == $past(oc_change_reg) && rd_data_o[16] == 1'b0)
		else $error("hub status word misplaced");

	a_wake_clear: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		wr_status && wr_data_i[31] |=> !wake_enable_reg)
		else $error("remote wake enable not cleared");

	a_oc_change_set: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		clk_en_i && oc_changed |=> oc_change_reg ##1 (oc_change_reg || $past(wr_status)))
		else $error("overcurrent change flag not set");

	a_global_on_all: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		!power_switch_select_i && global_on && !global_off |=> &port_power_o)
		else $error("global power on missed a port");

	a_global_off_all: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		!power_switch_select_i && global_off |=> port_power_o == '0)
		else $error("global power off missed a port");

endmodule // root_hub_power_status_regs

// ==== verif/host_cpu_model.sv ====
// processor-side model that issues command codes to the root-hub registers
`timescale 1ns/1ps

module host_cpu_model
(
	// clock
	input  wire logic   ref_clk_i,
	// command port
	output logic        cmd_valid_o,
	output logic [7:0]  cmd_code_o,
	output logic [31:0] wr_data_o
);
	initial
	begin
		cmd_valid_o = 1'b0;
		cmd_code_o  = 8'h00;
		wr_data_o   = 32'h0000_0000;
	end

	// ************************************************************
	// command cycles
	// ************************************************************
	// lines are scrambled once released so stale values never pass as live
	task automatic send(input logic [7:0] code, input logic [31:0] data);
		@(posedge ref_clk_i);
		cmd_valid_o <= 1'b1;
		cmd_code_o  <= code;
		wr_data_o   <= data;
		@(posedge ref_clk_i);
		cmd_valid_o <= 1'b0;
		cmd_code_o  <= ~code;
		wr_data_o   <= ~data;
	endtask

	task automatic status_wr(input logic [31:0] data);
		send(root_hub_pkg::CODE_STATUS_WR, data & 32'h8003_8001);
	endtask
endmodule // host_cpu_model

// ==== verif/root_hub_power_status_regs_tb.sv ====
// self-checking bench for the root-hub power and status registers
`timescale 1ns/1ps

module root_hub_power_status_regs_tb;

	// ************************************************************
	// bench state
	// ************************************************************
	logic        ref_clk_i;
	logic        reset_i;
	logic        clk_en;
	logic        cmd_valid;
	logic [7:0]  cmd_code;
	logic [31:0] wr_data;
	logic        rd_valid;
	logic [31:0] rd_data;
	logic        select;
	logic        overcurrent;
	logic [1:0]  port_on;
	logic [1:0]  port_off;
	logic [1:0]  power;
	logic [31:0] exp_q[$];
	logic [31:0] rnd;
	int          fails = 0;
	int          checked = 0;
	int          cycles = 0;

	host_cpu_model cpu (.ref_clk_i(ref_clk_i), .cmd_valid_o(cmd_valid), .cmd_code_o(cmd_code),
		.wr_data_o(wr_data));

	root_hub_power_status_regs #(.NUM_PORTS(2)) DUT (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
		.clk_en_i(clk_en), .cmd_valid_i(cmd_valid), .cmd_code_i(cmd_code), .wr_data_i(wr_data),
		.rd_valid_o(rd_valid), .rd_data_o(rd_data), .power_switch_select_i(select),
		.overcurrent_i(overcurrent), .port_power_on_i(port_on), .port_power_off_i(port_off),
		.port_power_o(power));

	initial
	begin
		ref_clk_i = 1'b0;
		forever #25 ref_clk_i = ~ref_clk_i;
	end

	// ************************************************************
	// compare and report
	// ************************************************************
	task automatic close_out();
		if (exp_q.size() != 0)
			fails++;
		if (fails == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic check_power(input logic [1:0] exp);
		@(negedge ref_clk_i);
		check_word("port_power", {30'h0, exp}, {30'h0, power});
	endtask

	task automatic read(input logic [7:0] code, input logic [31:0] exp);
		exp_q.push_back(exp);
		cpu.send(code, 32'h0000_0000);
	endtask

	task automatic pulse(input logic [1:0] on, input logic [1:0] off);
		@(posedge ref_clk_i);
		port_on  <= on;
		port_off <= off;
		@(posedge ref_clk_i);
		port_on  <= 2'b00;
		port_off <= 2'b00;
	endtask

	// read answers are matched in order against the noted expectations
	always @(posedge ref_clk_i)
	begin
		cycles <= cycles + 1;
		if (rd_valid === 1'b1)
			check_word("rd_data", exp_q.pop_front(), rd_data);
		if (cycles == 3000)
		begin
			fails++;
			close_out();
		end
	end

	// ************************************************************
	// main sequence
	// ************************************************************
	initial
	begin
		reset_i     = 1'b1;
		clk_en      = 1'b1;
		select      = 1'b0;
		overcurrent = 1'b0;
		port_on     = 2'b00;
		port_off    = 2'b00;
		rnd         = $urandom(39278);
		repeat (8) @(posedge ref_clk_i);
		reset_i <= 1'b0;
		read(root_hub_pkg::CODE_DESC_B_RD, 32'h0000_0000);
		read(root_hub_pkg::CODE_STATUS_RD, 32'h0000_0000);
		check_power(2'b00);
		rnd = $urandom();
		cpu.send(root_hub_pkg::CODE_DESC_B_WR, rnd);
		read(root_hub_pkg::CODE_DESC_B_RD, rnd & 32'h0006_0006);
		// global mode: mask disregarded, per-port commands ignored
		cpu.status_wr(32'h0001_0000);
		check_power(2'b11);
		pulse(2'b00, 2'b11);
		check_power(2'b11);
		cpu.status_wr(32'h0000_0001);
		check_power(2'b00);
		// per-port mode with port one masked
		select <= 1'b1;
		cpu.send(root_hub_pkg::CODE_DESC_B_WR, 32'h0002_0004);
		cpu.status_wr(32'h0001_0000);
		check_power(2'b10);
		pulse(2'b01, 2'b00);
		check_power(2'b11);
		pulse(2'b00, 2'b10);
		check_power(2'b11);
		cpu.status_wr(32'h0000_0001);
		check_power(2'b01);
		pulse(2'b00, 2'b01);
		check_power(2'b00);
		// clock enable low: commands and pulses must leave all state frozen
		@(posedge ref_clk_i);
		clk_en <= 1'b0;
		cpu.status_wr(32'h0001_0000);
		cpu.send(root_hub_pkg::CODE_DESC_B_WR, 32'hFFFF_FFFF);
		cpu.send(root_hub_pkg::CODE_DESC_B_RD, 32'h0000_0000);
		pulse(2'b01, 2'b00);
		check_power(2'b00);
		@(posedge ref_clk_i);
		clk_en <= 1'b1;
		read(root_hub_pkg::CODE_DESC_B_RD, 32'h0002_0004);
		// remote wake enable set, kept on a zero write, cleared by bit 31
		cpu.status_wr(32'h0000_8000);
		read(root_hub_pkg::CODE_STATUS_RD, 32'h0000_8000);
		cpu.status_wr(32'h0000_0000);
		read(root_hub_pkg::CODE_STATUS_RD, 32'h0000_8000);
		cpu.status_wr(32'h8000_0000);
		read(root_hub_pkg::CODE_STATUS_RD, 32'h0000_0000);
		// overcurrent change flag, then an unknown code that must do nothing
		@(posedge ref_clk_i);
		overcurrent <= 1'b1;
		read(root_hub_pkg::CODE_STATUS_RD, 32'h0002_0002);
		cpu.status_wr(32'h0000_0000);
		read(root_hub_pkg::CODE_STATUS_RD, 32'h0002_0002);
		cpu.status_wr(32'h0002_0000);
		cpu.send(8'h55, 32'hFFFF_FFFF);
		read(root_hub_pkg::CODE_STATUS_RD, 32'h0000_0002);
		// overcurrent change in the clearing cycle: the set wins
		fork
			cpu.status_wr(32'h0002_0000);
			begin
				@(posedge ref_clk_i);
				overcurrent <= 1'b0;
			end
		join
		read(root_hub_pkg::CODE_STATUS_RD, 32'h0002_0000);
		check_power(2'b00);
		repeat (3) @(posedge ref_clk_i);
		close_out();
	end
endmodule // root_hub_power_status_regs_tb
